// >>> core/adc_pkg.sv
// What this block does
// (RULE1) chip-select level accepted only after held 1.425 us; shorter glitches ignored
// (RULE2) after chip select falls, ignore serial clock and address until filter passes
// (RULE3) host waits the chip-select setup interval before shifting an address
// (RULE4) chip select rising disables address and serial clock within filter time
// (RULE5) held-low chip select: host clocks next transfer only after end-of-conversion rises
// (RULE6) without chip select, eleventh rising clock must precede conversion end
// (RULE7) without chip select, host supplies exactly sixteen clocks per transfer
// (RULE8) framed transfers of eleven to sixteen clocks all work correctly
// (RULE9) end-of-conversion goes low after falling edge of tenth serial clock
// (RULE10) channel sampled during a six serial clock acquisition window
// (RULE11) chip select falling within 9 us after tenth clock aborts conversion
package adc_pkg;
   localparam int unsigned MCLK_HZ = 40000000;
   // chip-select filter time in picoseconds (1.425 us), least time rounds up
   localparam longint unsigned CS_FILT_PS = 1425000;
   localparam int unsigned CS_FILT_CYC =
      int'((CS_FILT_PS * MCLK_HZ + 64'd999999999999) / 64'd1000000000000);
   // conversion time in nanoseconds (21 us), a longest time rounds down
   localparam longint unsigned CONV_NS = 21000;
   localparam int unsigned CONV_CYC = int'((CONV_NS * MCLK_HZ) / 1000000000);
   // abort window after the tenth clock in nanoseconds (9 us)
   localparam longint unsigned ABORT_NS = 9000;
   localparam int unsigned ABORT_CYC = int'((ABORT_NS * MCLK_HZ) / 1000000000);
   localparam logic [3:0] ACQ_FIRST = 4'h4; // acquisition opens after 4th clock
   localparam logic [3:0] ACQ_LEN = 4'h6;   // six serial clock periods
   localparam logic [3:0] CONV_START = 4'hA; // tenth falling edge
   localparam logic [3:0] MAX_CLKS = 4'hF;  // count wraps to zero after 15; 16 in total
   localparam int unsigned RES_BITS = 10;
   localparam int unsigned ADDR_BITS = 4;
   // events passed from the link domain to the core domain
   typedef struct packed {
      logic [3:0] chan;   // channel captured by the shift register
      logic [9:0] sample; // value held at end of acquisition
   } conv_req_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b11
   } conv_state_t;
endpackage

// >>> core/adc_serial_host_interface.sv
// serial host interface of a 10-bit converter; link logic runs on sclk
// the host frames a transfer with cs_n, clocks a 4-bit channel in on addr_in
// and reads the previous 10-bit result on dout, msb first
// cs_n is filtered on mclk, so a select only counts once it has stood still
// for the whole filter time; short pulses never reach the link logic
// sclk may stop between frames, so the link side cannot rely on seeing the
// deselect level: each accepted select toggles a frame id instead, and the
// link logic restarts its counters when it notices a new id
// the frame id needs three sclk rising edges to cross, so a host that opens
// a frame gives three idle clocks before the first address bit
// the conversion itself is timed on mclk; the start crosses as a toggle
// limitation: the converter value is taken as one word at the tenth falling
// sclk edge, the successive approximation steps are not modelled
module adc_serial_host_interface (
   // core clock and reset
   input wire logic mclk,
   input wire logic rst,
   // host serial pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic addr_in,
   output logic dout,
   output logic dout_oe,
   // converter side
   input wire logic [9:0] analog_code,
   output logic [3:0] mux_chan,
   output logic sampling,
   output logic eoc
);
   // ---------------- core domain: chip-select path ----------------
   logic cs_m_q, cs_s_q, cs_filt;
   // pin passes two flops before anything looks at it
   always_ff @(posedge mclk) begin
      if (rst) begin
         cs_m_q <= 1'b1;
         cs_s_q <= 1'b1;
      end else begin
         cs_m_q <= cs_n;
         cs_s_q <= cs_m_q;
      end
   end

   cs_filter u_filt (
      .mclk(mclk),
      .rst(rst),
      .cs_n_sync(cs_s_q),
      .cs_n_filt(cs_filt)
   );

   // (RULE2) enable link only after filtered low
   // (RULE4) filtered high disables link inputs
   logic link_en_q;
   always_ff @(posedge mclk) begin
      if (rst) link_en_q <= 1'b0;
      else link_en_q <= ~cs_filt;
   end

   // ---------------- link domain (sclk) ----------------
   // enable crosses into sclk through two flops
   logic en_m_q, en_s_q;
   logic fid_q, fid_m_q, fid_s_q, fid_seen_q;
   logic link_act;
   always_ff @(posedge sclk) begin
      en_m_q <= link_en_q;
      en_s_q <= en_m_q;
   end

   // (RULE2) frame id crosses too; a stale enable left from a frame whose
   // clock stopped cannot run on into the next frame
   always_ff @(posedge sclk) begin
      fid_m_q <= fid_q;
      fid_s_q <= fid_m_q;
      fid_seen_q <= fid_s_q;
   end

   // link counts only inside a frame whose id has been seen
   assign link_act = en_s_q && (fid_s_q == fid_seen_q);

   logic [3:0] bit_cnt_q;
   logic [3:0] addr_sr_q;
   logic [9:0] out_sr_q;
   logic [3:0] chan_q;
   logic samp_q;
   logic conv_tgl_q;
   logic [9:0] held_q;
   logic [9:0] result_s;

   // (RULE8) count 11..16 clocks; the count wraps to zero after 15
   // (RULE7) sixteen-clock frames wrap the count naturally
   always_ff @(posedge sclk) begin
      if (!link_act) bit_cnt_q <= 4'h0;
      else if (bit_cnt_q != adc_pkg::MAX_CLKS) bit_cnt_q <= bit_cnt_q + 4'h1;
      else bit_cnt_q <= 4'h0;
   end

   // address shifts in MSB first on the first four rising edges
   always_ff @(posedge sclk) begin
      if (!link_act) addr_sr_q <= 4'h0;
      else if (bit_cnt_q < 4'(adc_pkg::ADDR_BITS))
         addr_sr_q <= {addr_sr_q[2:0], addr_in};
   end

   // (RULE10) six-clock acquisition window
   always_ff @(posedge sclk) begin
      if (!link_act) begin
         samp_q <= 1'b0;
         chan_q <= 4'h0;
      end else if (bit_cnt_q == adc_pkg::ACQ_FIRST - 4'h1) begin
         samp_q <= 1'b1;
         chan_q <= {addr_sr_q[2:0], addr_in};
      end else if (bit_cnt_q == adc_pkg::ACQ_FIRST + adc_pkg::ACQ_LEN - 4'h1)
         samp_q <= 1'b0;
   end

   // result shifts out msb first; the msb is shown straight from the result
   // while the count is zero, so a held-low select still sees a fresh word
   // after end-of-conversion, although sclk stood still meanwhile
   always_ff @(negedge sclk) begin
      if (bit_cnt_q == 4'h1) out_sr_q <= {result_s[8:0], 1'b0};
      else out_sr_q <= {out_sr_q[8:0], 1'b0};
   end

   // (RULE9) tenth falling edge starts conversion; toggle crosses domains
   always_ff @(negedge sclk) begin
      if (rst) begin
         conv_tgl_q <= 1'b0;
         held_q <= 10'h000;
      end else if (link_act && bit_cnt_q == adc_pkg::CONV_START) begin
         conv_tgl_q <= ~conv_tgl_q;
         held_q <= analog_code;
      end
   end

   // ---------------- core domain: conversion ----------------
   logic t_m_q, t_s_q, t_d_q;
   always_ff @(posedge mclk) begin
      if (rst) begin
         t_m_q <= 1'b0;
         t_s_q <= 1'b0;
         t_d_q <= 1'b0;
      end else begin
         t_m_q <= conv_tgl_q;
         t_s_q <= t_m_q;
         t_d_q <= t_s_q;
      end
   end
   logic start_p;
   assign start_p = t_s_q ^ t_d_q;

   adc_pkg::conv_state_t st_q;
   logic [15:0] tmr_q;
   logic [9:0] res_q;
   logic cs_filt_d_q;
   logic cs_fall;
   always_ff @(posedge mclk) begin
      if (rst) cs_filt_d_q <= 1'b1;
      else cs_filt_d_q <= cs_filt;
   end
   assign cs_fall = cs_filt_d_q & ~cs_filt;

   // (RULE2) frame id toggles on each accepted select
   always_ff @(posedge mclk) begin
      if (rst) fid_q <= 1'b0;
      else if (cs_fall) fid_q <= ~fid_q;
   end

   // conversion timer; held_q changes with the toggle and is stable long before res_q takes it
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q <= adc_pkg::ST_IDLE;
         tmr_q <= 16'h0000;
         res_q <= 10'h000;
      end else begin
         case (st_q)
            adc_pkg::ST_IDLE: begin
               if (start_p) begin
                  st_q <= adc_pkg::ST_CONV;
                  tmr_q <= 16'h0000;
               end
            end
            adc_pkg::ST_CONV: begin
               tmr_q <= tmr_q + 16'h0001;
               // (RULE11) chip select falling in window aborts
               if (cs_fall && tmr_q < 16'(adc_pkg::ABORT_CYC))
                  st_q <= adc_pkg::ST_IDLE;
               else if (tmr_q == 16'(adc_pkg::CONV_CYC - 1)) begin
                  st_q <= adc_pkg::ST_DONE;
                  res_q <= held_q;
               end
            end
            adc_pkg::ST_DONE: st_q <= adc_pkg::ST_IDLE;
            default: st_q <= adc_pkg::ST_IDLE;
         endcase
      end
   end

   // (RULE9) end-of-conversion low while converting
   always_ff @(posedge mclk) begin
      if (rst) eoc <= 1'b1;
      else eoc <= (st_q != adc_pkg::ST_CONV) && !start_p;
   end

   // result only changes outside a frame, so the link reads it quasi-static
   assign result_s = res_q;

   // pin outputs
   assign dout = (bit_cnt_q == 4'h0) ? result_s[9] : out_sr_q[9];
   // (RULE4) enable follows the filtered select, no sclk edge needed
   assign dout_oe = link_en_q;
   assign mux_chan = chan_q;
   assign sampling = samp_q;
endmodule

// >>> core/cs_filter.sv
// chip-select deglitcher: a level is accepted once stable for CS_FILT_CYC
module cs_filter (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // raw pin, already synchronised
   input wire logic cs_n_sync,
   // filtered level
   output logic cs_n_filt
);
   logic [7:0] cnt_q;
   // (RULE1) stability count filter
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_q <= 8'h00;
         cs_n_filt <= 1'b1;
      end else if (cs_n_sync == cs_n_filt) begin
         cnt_q <= 8'h00;
      end else if (cnt_q == 8'(adc_pkg::CS_FILT_CYC - 1)) begin
         cnt_q <= 8'h00;
         cs_n_filt <= cs_n_sync;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule

// >>> test/adc_properties.sv
module adc_checker (
   // core side
   input wire logic mclk,
   input wire logic rst,
   // host pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic addr_in,
   input wire logic dout,
   input wire logic dout_oe,
   // converter side
   input wire logic [9:0] analog_code,
   input wire logic [3:0] mux_chan,
   input wire logic sampling,
   input wire logic eoc
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_oe_filtered: assert property ($rose(dout_oe) |-> !$past(cs_n, 50))
      else $error("link enabled before select settled");
   a_acq_selected: assert property ($rose(sampling) |-> !cs_n)
      else $error("acquisition while deselected");
   a_conv_selected: assert property ($fell(eoc) |-> !$past(cs_n, 8))
      else $error("conversion started while deselected");
   a_acq_then_conv: assert property ($fell(sampling) |-> ##[1:8] !eoc)
      else $error("no conversion after acquisition");
   a_conv_held: assert property ($fell(eoc) |=> !eoc [*8])
      else $error("end of conversion glitched");
   a_conv_bounded: assert property ($fell(eoc) |-> ##[1:900] eoc)
      else $error("conversion never ended");
   a_acq_idle: assert property (sampling |-> eoc)
      else $error("acquisition during conversion");
   a_chan_held: assert property (!eoc |-> $stable(mux_chan))
      else $error("channel moved during conversion");
   c_conv: cover property ($fell(eoc));
   c_done: cover property ($rose(eoc));
   c_acq: cover property ($rose(sampling));
endmodule
bind adc_serial_host_interface adc_checker u_chk (.mclk, .rst, .cs_n,
   .sclk, .addr_in, .dout, .dout_oe, .analog_code, .mux_chan, .sampling,
   .eoc);

// >>> test/host_model.sv
module host_model (
   // core clock for setup timing
   input wire logic mclk,
   // host pins
   output logic cs_n,
   output logic sclk,
   output logic addr_in,
   input wire logic dout,
   // bits seen on sclk rising
   output logic [15:0] rx_q
);
   timeunit 1ns;
   timeprecision 100ps;
   // idle: deselected, clock stopped low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      addr_in = 1'b0;
      rx_q = 16'h0000;
   end
   // one link clock pulse, data captured at the rise
   task pulse(input logic a);
      addr_in = a;
      #7.5 sclk = 1'b1;
      rx_q = {rx_q[14:0], dout};
      #7.5 sclk = 1'b0;
   endtask
   // keep leaves select low so the next frame skips setup
   task frame(input logic [3:0] ch, input int n, input bit keep);
      if (cs_n) begin
         cs_n = 1'b0;
         repeat (70) @(posedge mclk);
         // three idle clocks carry the new frame into the link
         pulse(~addr_in);
         pulse(~addr_in);
         pulse(~addr_in);
      end
      // msb first, clocks after the tenth fall well inside a conversion
      for (int i = 0; i < n; i++) pulse(i < 4 ? ch[3 - i] : ~addr_in);
      addr_in = ~addr_in; // line toggled, no stale value
      if (!keep) cs_n = 1'b1;
   endtask
   task glitch;
      cs_n = 1'b0;
      repeat (20) @(posedge mclk);
      cs_n = 1'b1;
      for (int i = 0; i < 11; i++) pulse(1'b1);
   endtask
endmodule

// >>> test/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, rst, cs_n, sclk, addr_in, dout, dout_oe, sampling, eoc;
   logic [9:0] code;
   logic [3:0] mux_chan;
   logic [15:0] rx_q;
   logic [10:0] prev = 11'h400;
   int num_errors, n_tests, cyc;
   adc_serial_host_interface u_adc_serial_host_interface (.mclk, .rst,
      .cs_n, .sclk, .addr_in, .dout, .dout_oe, .analog_code(code),
      .mux_chan, .sampling, .eoc);
   host_model u_host_model (.mclk, .cs_n, .sclk, .addr_in, .dout, .rx_q);
   // core clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task final_report;
      if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // bounded wait on eoc, c counts cycles
   task wait_eoc(input logic lvl, output int c);
      c = 0;
      while (eoc !== lvl && c < 2000) begin
         @(posedge mclk);
         c++;
      end
   endtask
   // one conversion; previous result must come out first
   task t_conv(input logic [3:0] ch, input int n, input bit keep);
      int c;
      @(posedge mclk);
      code <= {ch, 6'h2B} ^ 10'(n);
      u_host_model.frame(ch, n, keep);
      if (!prev[10]) chk((rx_q >> (n - 10)) & 16'h3FF, 16'(prev[9:0]));
      prev = {1'b0, code};
      wait_eoc(1'b0, c);
      chk(16'(c < 20), 16'h0001);
      chk(16'(mux_chan), 16'(ch));
      chk(16'(sampling), 16'h0000);
      // next frame only after end-of-conversion rises
      wait_eoc(1'b1, c);
      chk(16'(c > 820 && c < 850), 16'h0001);
      chk(16'(dout_oe), 16'(keep));
   endtask
   // every framed length, then select held low
   task t_sizes;
      for (int n = 11; n <= 16; n++) t_conv(4'(n), n, 1'b0);
      t_conv(4'h3, 16, 1'b1);
      t_conv(4'h9, 16, 1'b1);
      t_conv(4'hA, 16, 1'b0);
   endtask
   // reselect soon after start cancels the conversion
   task t_abort;
      int c;
      u_host_model.frame(4'h6, 11, 1'b0);
      wait_eoc(1'b0, c);
      repeat (80) @(posedge mclk);
      u_host_model.frame(4'h0, 0, 1'b1);
      wait_eoc(1'b1, c);
      chk(16'(c < 300), 16'h0001);
      u_host_model.frame(4'h0, 0, 1'b0);
      repeat (80) @(posedge mclk);
      chk(16'(dout_oe), 16'h0000);
      prev = 11'h400;
   endtask
   // glitch and clocks while deselected start nothing
   task t_glitch;
      u_host_model.glitch;
      repeat (200) @(posedge mclk);
      chk(16'(eoc), 16'h0001);
      chk(16'(dout_oe), 16'h0000);
   endtask
   // timeout guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         final_report;
      end
   end
   // reset with link flushed, then scenarios
   initial begin
      rst = 1'b1;
      code = 10'h000;
      for (int i = 0; i < 4; i++) u_host_model.pulse(1'b0);
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      t_sizes;
      t_abort;
      t_glitch;
      final_report;
   end
endmodule
